// File: rtl/tcpc_alert_pkg.sv
// Shared constants and carrier types for the alert and identity register block
package tcpc_alert_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_VENDOR_LO = 8'h00;
  localparam logic [7:0] ADDR_VENDOR_HI = 8'h01;
  localparam logic [7:0] ADDR_PRODUCT_LO = 8'h02;
  localparam logic [7:0] ADDR_PRODUCT_HI = 8'h03;
  localparam logic [7:0] ADDR_PART_LO = 8'h04;
  localparam logic [7:0] ADDR_PART_HI = 8'h05;
  localparam logic [7:0] ADDR_CONN_LO = 8'h06;
  localparam logic [7:0] ADDR_CONN_HI = 8'h07;
  localparam logic [7:0] ADDR_POWER_LO = 8'h08;
  localparam logic [7:0] ADDR_POWER_HI = 8'h09;
  localparam logic [7:0] ADDR_CTRL_LO = 8'h0a;
  localparam logic [7:0] ADDR_CTRL_HI = 8'h0b;
  localparam logic [7:0] ADDR_FLAGS0 = 8'h10;
  localparam logic [7:0] ADDR_FLAGS1 = 8'h11;
  localparam logic [7:0] ADDR_ENABLE0 = 8'h12;
  localparam logic [7:0] ADDR_ENABLE1 = 8'h13;
  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] FLAGS0_RST = 8'h02;
  localparam logic [7:0] FLAGS1_RST = 8'h02;
  localparam logic [7:0] ENABLE0_RST = 8'hff;
  localparam logic [7:0] ENABLE1_RST = 8'h0f;
  localparam logic [7:0] FLAGS1_IMPL = 8'h8f;
  localparam int B0_OVER = 7;
  localparam int B0_TX_OK = 6;
  localparam int B0_TX_DROP = 5;
  localparam int B0_TX_FAIL = 4;
  localparam int B0_HARD_RST = 3;
  localparam int B0_RX_MSG = 2;
  localparam int B0_POWER = 1;
  localparam int B0_CC = 0;
  localparam int B1_VENDOR = 7;
  localparam int B1_SINK = 3;
  localparam int B1_OVF = 2;
  localparam int B1_FAULT = 1;
  localparam int B1_UNDER = 0;
  // ****************************************
  // Identity defaults (all values arbitrary) and link constants
  // ****************************************
  localparam logic [15:0] VENDOR_CODE_DEF = 16'ha5c3;
  localparam logic [15:0] PRODUCT_CODE_DEF = 16'h7e41;
  localparam logic [15:0] PART_CODE_DEF = 16'h0102;
  localparam logic [15:0] CONN_REV_DEF = 16'h0203;
  localparam logic [15:0] POWER_REV_DEF = 16'h0405;
  localparam logic [15:0] CTRL_REV_DEF = 16'h0709;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Register access carried from the link domain to the core domain
  typedef struct packed {
    logic wr;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
  } reg_req_s;
  // One-cycle event strobes from the surrounding port logic
  typedef struct packed {
    logic tx_ok;
    logic tx_drop;
    logic tx_fail;
    logic link_reset;
    logic hard_rst;
    logic rx_changed;
    logic rx_count_zeroed;
    logic cc_changed;
    logic bus_over;
    logic bus_under;
    logic sink_cross;
    logic rx_overflow;
    logic fault;
  } port_event_s;
endpackage

// File: rtl/tcpc_alert_regs.sv
// Alert flags, enables, identity bytes and interrupt line of the port PHY
//
// Behaviour
// - Read-only 16-bit vendor code, two bytes
// - Read-only product and part codes, two bytes
// - Read-only power spec revision, two bytes
// - Read-only controller and connector revisions
// - Initialisation done sets power change flag
// - Flags byte 0 resets to 0x02
// - Unmasked set flag pulls int_n low
// - Write one clears; int_n rises when clear
// - Tx success or reset sets ok flag
// - Tx discard or reset sets dropped flag
// - Missing acknowledge sets tx failure flag
// - Received hard reset sets its flag
// - Receive change sets flag, not count zero
// - Channel status change sets its flag
// - Over-voltage crossing sets byte 0 flag
// - Under-voltage crossing sets byte 1 flag
// - Vendor source sets flag; clearable while active
// - Sink detach flag only with auto-discharge
// - Overflow blocks acknowledge until receive flag cleared
// - Reset sets fault flag; byte 1 reads 0x02
// - Masked flags ignored; enable 0 resets 0xff
// - Enable byte 1 resets to 0x0f
`timescale 1ns/1ps
module tcpc_alert_regs
  import tcpc_alert_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = VENDOR_CODE_DEF, // Arbitrary value
  parameter logic [15:0] PRODUCT_CODE = PRODUCT_CODE_DEF, // Arbitrary value
  parameter logic [15:0] PART_CODE = PART_CODE_DEF, // Arbitrary value
  parameter logic [15:0] CONN_REV = CONN_REV_DEF, // Arbitrary value
  parameter logic [15:0] POWER_REV = POWER_REV_DEF, // Arbitrary value
  parameter logic [15:0] CTRL_REV = CTRL_REV_DEF, // Arbitrary value
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF // Own link address
)(
  input wire logic mclk, // Core clock, 200 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic link_clk, // Link oversampling clock
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin in
  output logic sda_o, // Serial data pin out
  output logic sda_oe, // Serial data pin enable
  input wire port_event_s evt, // Event strobes, core clock
  input wire logic vendor_src, // Vendor source level
  input wire logic init_done, // Initialisation done level
  input wire logic auto_disc_en, // Auto-discharge on detach
  output logic int_n, // Interrupt line, active low
  output logic tx_buf_clear, // Transmit buffer empty pulse
  output logic goodcrc_block, // Stop acknowledging messages
  output logic allreg_reset_flag // Reset-to-default fault status
);
  // ****************************************
  // State of the core side
  // ****************************************
  typedef struct packed {
    logic [7:0] flags0; // Event flags byte 0
    logic [7:0] flags1; // Event flags byte 1
    logic [7:0] enable0; // Per-flag enables byte 0
    logic [7:0] enable1; // Per-flag enables byte 1
    logic no_ack; // Overflow condition held
    logic allreg; // Reset-to-default status
    logic vendor_q; // Vendor level last cycle
    logic init_q; // Init level last cycle
    logic req_s1; // Request toggle, first stage
    logic req_s2; // Request toggle, second stage
    logic req_q; // Request toggle, last seen
    logic ack_tgl; // Answer toggle
    logic [7:0] rdata; // Answer byte
    logic tx_clear; // Buffer empty pulse
    logic int_n; // Registered interrupt line
  } core_state_s;

  // Power-up image of the core state
  localparam core_state_s CORE_RST = '{
    flags0: FLAGS0_RST,
    flags1: FLAGS1_RST,
    enable0: ENABLE0_RST,
    enable1: ENABLE1_RST,
    no_ack: 1'b0,
    allreg: 1'b1,
    vendor_q: 1'b0,
    init_q: 1'b0,
    req_s1: 1'b0,
    req_s2: 1'b0,
    req_q: 1'b0,
    ack_tgl: 1'b0,
    rdata: 8'h00,
    tx_clear: 1'b0,
    int_n: 1'b0 // Power flag is set and enabled
  };

  core_state_s s; // Current state
  core_state_s next_s; // Next state
  logic link_req_tgl; // Request toggle from link side
  reg_req_s link_req; // Request from link side
  logic access; // Request has crossed
  logic wr_hit; // Access carries a write
  logic [7:0] set0; // Hardware sets byte 0
  logic [7:0] set1; // Hardware sets byte 1
  logic [7:0] clr0; // Software clears byte 0
  logic [7:0] clr1; // Software clears byte 1

  // ****************************************
  // Link side
  // ****************************************
  // The link logic runs on its own clock; only toggles and
  // held words pass between the two domains.
  tcpc_link_slave u_link (
    .link_clk(link_clk),
    .arst_n(arst_n),
    .dev_addr(DEV_ADDR),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .req_tgl(link_req_tgl),
    .req(link_req),
    .ack_tgl(s.ack_tgl),
    .rdata(s.rdata)
  );

  // ****************************************
  // Register read decode
  // ****************************************
  // Reads have no side effects, so the link may prefetch freely.
  function automatic logic [7:0] read_byte(input logic [7:0] a,
                                           input core_state_s st);
    logic [7:0] v;
    v = 8'h00; // Unmapped offsets read zero
    unique case (a)
      ADDR_VENDOR_LO: v = VENDOR_CODE[7:0];
      ADDR_VENDOR_HI: v = VENDOR_CODE[15:8];
      ADDR_PRODUCT_LO: v = PRODUCT_CODE[7:0];
      ADDR_PRODUCT_HI: v = PRODUCT_CODE[15:8];
      ADDR_PART_LO: v = PART_CODE[7:0];
      ADDR_PART_HI: v = PART_CODE[15:8];
      ADDR_CONN_LO: v = CONN_REV[7:0];
      ADDR_CONN_HI: v = CONN_REV[15:8];
      ADDR_POWER_LO: v = POWER_REV[7:0];
      ADDR_POWER_HI: v = POWER_REV[15:8];
      ADDR_CTRL_LO: v = CTRL_REV[7:0];
      ADDR_CTRL_HI: v = CTRL_REV[15:8];
      ADDR_FLAGS0: v = st.flags0;
      ADDR_FLAGS1: v = st.flags1 & FLAGS1_IMPL;
      ADDR_ENABLE0: v = st.enable0;
      ADDR_ENABLE1: v = st.enable1;
      default: v = 8'h00;
    endcase
    read_byte = v;
  endfunction

  // ****************************************
  // Crossing and write strobes
  // ****************************************
  // Request toggle seen after two stages; the held request word
  // was stable well before the toggle was.
  assign access = s.req_s2 ^ s.req_q;
  assign wr_hit = access & link_req.wr;

  // Write-one-to-clear masks; identity offsets take no write
  always_comb begin
    clr0 = 8'h00;
    clr1 = 8'h00;
    if (wr_hit && link_req.waddr == ADDR_FLAGS0) begin
      clr0 = link_req.wdata; // Zero bits keep their flag
    end
    if (wr_hit && link_req.waddr == ADDR_FLAGS1) begin
      clr1 = link_req.wdata & FLAGS1_IMPL; // Reserved bits ignored
    end
  end

  // ****************************************
  // Hardware event sets
  // ****************************************
  // Byte 0 sources
  always_comb begin
    set0 = 8'h00;
    set0[B0_OVER] = evt.bus_over;
    set0[B0_TX_OK] = evt.tx_ok | evt.link_reset;
    set0[B0_TX_DROP] = evt.tx_drop | evt.link_reset;
    set0[B0_TX_FAIL] = evt.tx_fail;
    set0[B0_HARD_RST] = evt.hard_rst;
    // A plain return of the byte count to zero is not news
    set0[B0_RX_MSG] = evt.rx_changed & ~evt.rx_count_zeroed;
    set0[B0_POWER] = init_done & ~s.init_q;
    set0[B0_CC] = evt.cc_changed;
  end

  // Byte 1 sources
  always_comb begin
    set1 = 8'h00;
    // Edge of the vendor level, so a clear sticks while it stays high
    set1[B1_VENDOR] = vendor_src & ~s.vendor_q;
    set1[B1_SINK] = evt.sink_cross & auto_disc_en;
    set1[B1_OVF] = evt.rx_overflow;
    set1[B1_FAULT] = evt.fault;
    set1[B1_UNDER] = evt.bus_under;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    // Two-stage capture of the link request toggle
    next_s.req_s1 = link_req_tgl;
    next_s.req_s2 = s.req_s1;
    next_s.req_q = s.req_s2;
    // Level histories for edge sources
    next_s.vendor_q = vendor_src;
    next_s.init_q = init_done;

    // Set wins over a clear landing in the same cycle
    next_s.flags0 = (s.flags0 & ~clr0) | set0;
    next_s.flags1 = ((s.flags1 & ~clr1) | set1) & FLAGS1_IMPL;

    // Enable bytes are plain read-write
    if (wr_hit && link_req.waddr == ADDR_ENABLE0) begin
      next_s.enable0 = link_req.wdata;
    end
    if (wr_hit && link_req.waddr == ADDR_ENABLE1) begin
      next_s.enable1 = link_req.wdata;
    end

    // Overflow hold: only a clear of the receive flag ends it,
    // acknowledging the overflow flag alone does not
    if (clr0[B0_RX_MSG]) begin
      next_s.no_ack = 1'b0;
    end
    if (evt.rx_overflow) begin
      next_s.no_ack = 1'b1;
    end

    // Reset-to-default status falls when the fault flag is cleared
    if (clr1[B1_FAULT]) begin
      next_s.allreg = 1'b0;
    end

    // Any transmit outcome leaves the transmit buffer empty
    next_s.tx_clear = evt.tx_ok | evt.tx_drop | evt.tx_fail
                      | evt.link_reset;

    // Answer the link: read is taken before this cycle's write
    if (access) begin
      next_s.rdata = read_byte(link_req.raddr, s);
      next_s.ack_tgl = ~s.ack_tgl;
    end

    // Line low while any enabled flag stands; built from next
    // values so it moves in the same cycle as the flags
    next_s.int_n = ~|((next_s.flags0 & next_s.enable0)
                      | (next_s.flags1 & next_s.enable1));
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= CORE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign int_n = s.int_n;
  assign tx_buf_clear = s.tx_clear;
  assign goodcrc_block = s.no_ack;
  assign allreg_reset_flag = s.allreg;
endmodule

// File: rtl/tcpc_link_slave.sv
// Serial two-wire register link slave, running on the link clock
`timescale 1ns/1ps
module tcpc_link_slave
  import tcpc_alert_pkg::*;
(
  input wire logic link_clk, // Link oversampling clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [6:0] dev_addr, // Own bus address
  input wire logic scl_i, // Serial clock pin level
  input wire logic sda_i, // Serial data pin level
  output logic sda_o, // Serial data drive value
  output logic sda_oe, // Serial data pull-low enable
  output logic req_tgl, // Toggles once per access
  output reg_req_s req, // Access, stable while in flight
  input wire logic ack_tgl, // Core answer toggle
  input wire logic [7:0] rdata // Core answer byte
);
  typedef enum {L_IDLE, L_DEV, L_DEV_ACK, L_REG, L_REG_ACK, L_WR, L_WR_ACK, L_RD,
                L_RD_ACK} link_st_e;
  typedef struct packed {
    logic scl1, scl2, scl_q;
    logic sda1, sda2, sda_q;
    logic ack1, ack2, ack_q;
    link_st_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] rbuf;
    logic rw;
    logic oe;
    logic req_tgl;
    reg_req_s req;
  } link_state_s;
  link_state_s s, next_s;
  logic rise, fall, start, stop;
  // Build a new access; the read address is always prefetched
  function automatic reg_req_s make_req(input logic w, input logic [7:0] wa,
                                        input logic [7:0] wd, input logic [7:0] ra);
    make_req = '{wr: w, waddr: wa, wdata: wd, raddr: ra};
  endfunction
  // ****************************************
  // Line events from the second sync stage only
  // ****************************************
  assign rise = s.scl2 & ~s.scl_q;
  assign fall = ~s.scl2 & s.scl_q;
  assign start = s.scl2 & s.scl_q & s.sda_q & ~s.sda2;
  assign stop = s.scl2 & s.scl_q & ~s.sda_q & s.sda2;
  // Next state of the whole link slave
  always_comb begin
    next_s = s;
    next_s.scl1 = scl_i;
    next_s.scl2 = s.scl1;
    next_s.scl_q = s.scl2;
    next_s.sda1 = sda_i;
    next_s.sda2 = s.sda1;
    next_s.sda_q = s.sda2;
    next_s.ack1 = ack_tgl;
    next_s.ack2 = s.ack1;
    next_s.ack_q = s.ack2;
    // Answer byte is taken only after the toggle has crossed
    if (s.ack2 ^ s.ack_q) begin
      next_s.rbuf = rdata;
    end
    if (start) begin
      next_s.st = L_DEV;
      next_s.cnt = '0;
      next_s.oe = 1'b0;
    end else if (stop) begin
      next_s.st = L_IDLE;
      next_s.oe = 1'b0;
    end else if (rise) begin
      unique case (s.st)
        L_DEV, L_REG, L_WR: begin
          next_s.sh = {s.sh[6:0], s.sda2};
          next_s.cnt = s.cnt + 4'h1;
        end
        L_RD: next_s.cnt = s.cnt + 4'h1;
        L_RD_ACK: if (s.sda2) next_s.st = L_IDLE; // Master ended the read
        L_IDLE, L_DEV_ACK, L_REG_ACK, L_WR_ACK: ;
      endcase
    end else if (fall) begin
      unique case (s.st)
        L_DEV: if (s.cnt == BITS_PER_BYTE) begin
          if (s.sh[7:1] == dev_addr) begin
            next_s.oe = 1'b1;
            next_s.rw = s.sh[0];
            next_s.st = L_DEV_ACK;
          end else begin
            next_s.st = L_IDLE;
          end
        end
        L_REG: if (s.cnt == BITS_PER_BYTE) begin
          next_s.ptr = s.sh;
          next_s.oe = 1'b1;
          next_s.st = L_REG_ACK;
          next_s.req = make_req(1'b0, s.sh, 8'h00, s.sh);
          next_s.req_tgl = ~s.req_tgl;
        end
        L_WR: if (s.cnt == BITS_PER_BYTE) begin
          next_s.oe = 1'b1;
          next_s.st = L_WR_ACK;
          next_s.ptr = s.ptr + 8'h01;
          next_s.req = make_req(1'b1, s.ptr, s.sh, s.ptr + 8'h01);
          next_s.req_tgl = ~s.req_tgl;
        end
        L_RD: if (s.cnt == BITS_PER_BYTE) begin
          next_s.oe = 1'b0;
          next_s.st = L_RD_ACK;
        end else begin
          next_s.sh = {s.sh[6:0], 1'b0};
          next_s.oe = ~s.sh[6];
        end
        L_DEV_ACK, L_REG_ACK, L_WR_ACK, L_RD_ACK: begin
          next_s.cnt = '0;
          if ((s.st == L_DEV_ACK && s.rw) || s.st == L_RD_ACK) begin
            // Send the prefetched byte and prefetch the one after it
            next_s.sh = s.rbuf;
            next_s.oe = ~s.rbuf[7];
            next_s.ptr = s.ptr + 8'h01;
            next_s.req = make_req(1'b0, 8'h00, 8'h00, s.ptr + 8'h01);
            next_s.req_tgl = ~s.req_tgl;
            next_s.st = L_RD;
          end else begin
            next_s.oe = 1'b0;
            next_s.st = (s.st == L_DEV_ACK) ? L_REG : L_WR;
          end
        end
        L_IDLE: ;
      endcase
    end
  end
  // State register
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe = s.oe;
  assign req_tgl = s.req_tgl;
  assign req = s.req;
endmodule

// File: test/host_model.sv
// Two-wire host model playing the port manager
`timescale 1ns/1ps
module host_model (
  output logic scl, // Serial clock
  output logic pull, // High pulls data low
  input wire logic sda // Resolved data line
);
  // ****
  // Bus cycles
  // ****
  localparam time HALF = 100ns; // Eight link clocks per phase
  localparam time GAP = 1us; // Lets the read prefetch land
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Start or repeated start
  task automatic start();
    pull = 1'b0;
    #HALF scl = 1'b1;
    #HALF pull = 1'b1;
    #HALF scl = 1'b0;
  endtask
  // Stop, then bus idle
  task automatic stop();
    #HALF pull = 1'b1;
    #HALF scl = 1'b1;
    #HALF pull = 1'b0;
    #GAP;
  endtask
  // One bit; line sampled late in the high phase
  task automatic slot(input logic b, output logic s);
    #HALF pull = ~b;
    #HALF scl = 1'b1;
    #HALF s = sda;
    scl = 1'b0;
  endtask
  // Byte out, returns acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, s);
    ack = ~s;
    #GAP;
  endtask
  // Byte in; last byte is refused to end the read
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) slot(1'b1, b[i]);
    slot(last, s);
    #GAP;
  endtask
endmodule

// File: test/tb_tcpc_alert_and_id_regs.sv
// Self-checking bench for the alert and identity registers
`timescale 1ns/1ps
module tb_tcpc_alert_and_id_regs;
  import tcpc_alert_pkg::*;
  logic mclk, link_clk, arst_n; // Clocks and reset
  port_event_s evt; // Event strobes
  logic vendor_src, init_done, auto_disc_en; // Level inputs
  logic scl, pull, sda_o, sda_oe; // Link pins
  logic int_n, tx_buf_clear, goodcrc_block, allreg_reset_flag; // Outputs
  wire sda = !(pull | sda_oe); // Pulled-up wire
  int mismatches, tests_run; // Counters
  logic [7:0] rd [0:12]; // Burst read buffer
  // ****
  // Clocks and instances
  // ****
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Link clock, unrelated phase
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  tcpc_alert_regs i_tcpc_alert_regs (
    .mclk(mclk), .arst_n(arst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .evt(evt), .vendor_src(vendor_src),
    .init_done(init_done), .auto_disc_en(auto_disc_en), .int_n(int_n),
    .tx_buf_clear(tx_buf_clear), .goodcrc_block(goodcrc_block),
    .allreg_reset_flag(allreg_reset_flag));
  host_model i_host_model (.scl(scl), .pull(pull), .sda(sda));
  // ****
  // Shared tasks
  // ****
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    i_host_model.start();
    i_host_model.put_byte({DEV_ADDR_DEF, 1'b0}, k0);
    i_host_model.put_byte(a, k1);
    i_host_model.put_byte(d, k2);
    i_host_model.stop();
    check("write ack", {5'h0, k0, k1, k2}, 8'h07);
  endtask
  task automatic reg_rd(input logic [7:0] a, input int n);
    logic k;
    i_host_model.start();
    i_host_model.put_byte({DEV_ADDR_DEF, 1'b0}, k);
    i_host_model.put_byte(a, k);
    i_host_model.start();
    i_host_model.put_byte({DEV_ADDR_DEF, 1'b1}, k);
    for (int i = 0; i < n; i++) i_host_model.get_byte(i == n - 1, rd[i]);
    i_host_model.stop();
  endtask
  // One-cycle strobe, launched off the falling edge
  task automatic pulse(input port_event_s e);
    @(negedge mclk) evt = e;
    @(negedge mclk) evt = '0;
  endtask
  // Held long enough for both clocks
  task automatic apply_reset();
    arst_n = 1'b0;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    repeat (20) @(negedge mclk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    reg_rd(ADDR_FLAGS0, 4);
    check("flags0", rd[0], 8'h02);
    check("flags1", rd[1], 8'h02);
    check("enable0", rd[2], 8'hff);
    check("enable1", rd[3], 8'h0f);
    check("int rst", {7'h0, int_n}, 8'h00);
    check("allreg", {7'h0, allreg_reset_flag}, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_ident();
    logic [95:0] id;
    id = {CTRL_REV_DEF, POWER_REV_DEF, CONN_REV_DEF, PART_CODE_DEF, PRODUCT_CODE_DEF,
      VENDOR_CODE_DEF};
    reg_wr(ADDR_VENDOR_LO, 8'h55);
    reg_rd(ADDR_VENDOR_LO, 13);
    for (int i = 0; i < 12; i++) check("ident", rd[i], id[8*i +: 8]);
    check("unmapped", rd[12], 8'h00);
    $display("test ident done");
  endtask
  task automatic t_clear();
    reg_wr(ADDR_FLAGS0, 8'h00);
    reg_wr(ADDR_FLAGS1, 8'h70);
    reg_rd(ADDR_FLAGS0, 2);
    check("flags0 kept", rd[0], 8'h02);
    check("flags1 kept", rd[1], 8'h02);
    reg_wr(ADDR_FLAGS0, 8'h02);
    check("int one left", {7'h0, int_n}, 8'h00);
    reg_wr(ADDR_FLAGS1, 8'h02);
    check("int all clr", {7'h0, int_n}, 8'h01);
    check("allreg clr", {7'h0, allreg_reset_flag}, 8'h00);
    $display("test clear done");
  endtask
  task automatic t_events();
    pulse('{rx_count_zeroed: 1'b1, default: 1'b0});
    pulse('{sink_cross: 1'b1, default: 1'b0});
    check("int idle", {7'h0, int_n}, 8'h01);
    pulse('{tx_ok: 1'b1, default: 1'b0});
    check("int set", {7'h0, int_n}, 8'h00);
    @(negedge mclk) vendor_src = 1'b1;
    pulse('{tx_drop: 1'b1, tx_fail: 1'b1, hard_rst: 1'b1, rx_changed: 1'b1,
      cc_changed: 1'b1, bus_over: 1'b1, bus_under: 1'b1, sink_cross: 1'b1,
      rx_overflow: 1'b1, fault: 1'b1, default: 1'b0});
    reg_rd(ADDR_FLAGS0, 2);
    check("flags0 ev", rd[0], 8'hfd);
    check("flags1 ev", rd[1], 8'h87);
    check("block", {7'h0, goodcrc_block}, 8'h01);
    $display("test events done");
  endtask
  task automatic t_mask();
    reg_wr(ADDR_ENABLE0, 8'h00);
    reg_wr(ADDR_ENABLE1, 8'h00);
    check("int masked", {7'h0, int_n}, 8'h01);
    reg_wr(ADDR_ENABLE1, 8'h0f);
    check("int unmasked", {7'h0, int_n}, 8'h00);
    reg_wr(ADDR_FLAGS1, 8'h87); // Host acknowledges with ones
    reg_rd(ADDR_FLAGS1, 1);
    check("flags1 clr", rd[0], 8'h00);
    check("int byte1 clr", {7'h0, int_n}, 8'h01);
    check("block held", {7'h0, goodcrc_block}, 8'h01);
    reg_wr(ADDR_FLAGS0, 8'hfd);
    check("block free", {7'h0, goodcrc_block}, 8'h00);
    reg_wr(ADDR_ENABLE0, 8'hff);
    check("int none", {7'h0, int_n}, 8'h01);
    $display("test mask done");
  endtask
  task automatic t_late();
    @(negedge mclk) auto_disc_en = 1'b1;
    init_done = 1'b1;
    pulse('{sink_cross: 1'b1, link_reset: 1'b1, default: 1'b0});
    reg_rd(ADDR_FLAGS0, 2);
    check("flags0 late", rd[0], 8'h62);
    check("flags1 late", rd[1], 8'h08);
    check("int late", {7'h0, int_n}, 8'h00);
    $display("test late done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence, second reset after the last scenario
  initial begin
    arst_n = 1'b0;
    evt = '0;
    vendor_src = 1'b0;
    init_done = 1'b0;
    auto_disc_en = 1'b0;
    mismatches = 0;
    tests_run = 0;
    apply_reset();
    t_reset();
    t_ident();
    t_clear();
    t_events();
    t_mask();
    t_late();
    // Vendor source idle again, or its edge would set the flag after reset
    @(negedge mclk) vendor_src = 1'b0;
    apply_reset();
    t_reset();
    give_verdict();
  end
  // Watchdog; the run needs about 335 us, limit kept under 100k cycles
  initial begin
    #450us;
    mismatches++;
    give_verdict();
  end
endmodule

// File: test/tcpc_alert_props.sv
// Port-level assertions for the alert register block
`timescale 1ns/1ps
module tcpc_alert_checker
  import tcpc_alert_pkg::*;
(
  input wire logic mclk, // Core clock
  input wire logic arst_n, // Reset, active low
  input wire logic link_clk, // Link clock
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin in
  input wire logic sda_o, // Serial data out
  input wire logic sda_oe, // Serial data enable
  input wire port_event_s evt, // Event strobes
  input wire logic vendor_src, // Vendor source
  input wire logic init_done, // Init done level
  input wire logic auto_disc_en, // Auto-discharge enable
  input wire logic int_n, // Interrupt, active low
  input wire logic tx_buf_clear, // Buffer empty pulse
  input wire logic goodcrc_block, // Acknowledge blocked
  input wire logic allreg_reset_flag // Reset status
);
  // ****
  // Checks
  // ****
  logic tx_any; // Any transfer-ending strobe
  assign tx_any = evt.tx_ok | evt.tx_drop | evt.tx_fail | evt.link_reset;
  AST_RST_STATE: assert property (
    @(posedge mclk) disable iff (!arst_n)
    $rose(arst_n) |-> !int_n && allreg_reset_flag && !goodcrc_block)
    else $error("Reset state wrong after release");
  AST_TXCLR_AFTER: assert property (
    @(posedge mclk) disable iff (!arst_n) tx_any |=> tx_buf_clear)
    else $error("Transmit buffer not emptied");
  AST_TXCLR_CAUSE: assert property (
    @(posedge mclk) disable iff (!arst_n) tx_buf_clear |-> $past(tx_any))
    else $error("Buffer empty pulse without cause");
  AST_OVF_BLOCK: assert property (
    @(posedge mclk) disable iff (!arst_n) evt.rx_overflow |=> goodcrc_block)
    else $error("Overflow did not block acknowledge");
  AST_BLOCK_CAUSE: assert property (
    @(posedge mclk) disable iff (!arst_n)
    $rose(goodcrc_block) |-> $past(evt.rx_overflow))
    else $error("Acknowledge blocked without overflow");
  AST_FAULT_ONCE: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !allreg_reset_flag |=> !allreg_reset_flag)
    else $error("Reset status rose outside reset");
  AST_SDA_OPEN: assert property (
    @(posedge link_clk) disable iff (!arst_n) sda_oe |-> !sda_o)
    else $error("Data pin driven high");
  AST_SDA_LOWPH: assert property (
    @(posedge link_clk) disable iff (!arst_n) $rose(sda_oe) |-> !scl_i)
    else $error("Data pulled while clock high");
endmodule
bind tcpc_alert_regs tcpc_alert_checker i_tcpc_alert_checker (
  .mclk(mclk), .arst_n(arst_n), .link_clk(link_clk), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .evt(evt),
  .vendor_src(vendor_src), .init_done(init_done), .auto_disc_en(auto_disc_en),
  .int_n(int_n), .tx_buf_clear(tx_buf_clear), .goodcrc_block(goodcrc_block),
  .allreg_reset_flag(allreg_reset_flag));
